/* hdl/rbr_remap.sv */
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "rbr_map.svh"
module rbr_remap (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire rbr_pkg::rbr_byte_t reg_addr,
  input wire rbr_pkg::rbr_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output rbr_pkg::rbr_byte_t reg_rdata,
  input wire logic rx_lock,
  input wire logic learn_valid,
  input wire rbr_pkg::rbr_addr_t learn_addr,
  input wire logic req_valid,
  input wire rbr_pkg::rbr_addr_t req_addr,
  input wire logic req_rnw,
  output logic fwd_valid,
  output rbr_pkg::rbr_addr_t fwd_addr,
  output logic fwd_rnw,
  output logic req_reject
);
  import rbr_pkg::*;
  rbr_addr_t bridge_addr;
  logic hold_learned_address;
  rbr_addr_t bridge_alias;
  rbr_addr_t target_addr;
  rbr_addr_t target_alias;
  logic learned_once;
  rbr_sel_t sel;
  rbr_addr_t next_fwd_addr;
  logic next_ok;
  logic bridge_wr;
  logic learn_take;
  rbr_addr_t wr_field;

  function automatic rbr_addr_t addr_field(input rbr_byte_t b);
    addr_field = b[`RBR_ADDR_MSB:`RBR_ADDR_LSB];
  endfunction

  function automatic rbr_byte_t read_word(input rbr_addr_t a, input logic low);
    read_word = {a, low};
  endfunction

  rbr_decode u_decode (
    .req_addr(req_addr),
    .bridge_alias(bridge_alias),
    .target_alias(target_alias),
    .sel(sel)
  );

  assign wr_field = addr_field(reg_wdata);
  assign bridge_wr = reg_wr && (reg_addr == `RBR_OFS_BRIDGE_ADDR);

  assign learn_take = rx_lock && learn_valid && !hold_learned_address && !bridge_wr;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bridge_addr <= `RBR_RST_ADDR;
    end else if (bridge_wr) begin
      bridge_addr <= wr_field;
    end else if (learn_take) begin
      bridge_addr <= learn_addr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      hold_learned_address <= 1'b0;
    end else if (bridge_wr) begin
      hold_learned_address <= reg_wdata[`RBR_HOLD_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      learned_once <= 1'b0;
    end else if (learn_take) begin
      learned_once <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bridge_alias <= 7'h00;
      target_addr <= 7'h00;
      target_alias <= 7'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `RBR_OFS_BRIDGE_ALIAS: begin
          bridge_alias <= wr_field;
        end
        `RBR_OFS_TARGET_ADDR: begin
          target_addr <= wr_field;
        end
        `RBR_OFS_TARGET_ALIAS: begin
          target_alias <= wr_field;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= `RBR_RST_REG;
    end else if (reg_rd) begin
      case (reg_addr)
        `RBR_OFS_BRIDGE_ADDR: reg_rdata <= read_word(bridge_addr, hold_learned_address);
        `RBR_OFS_BRIDGE_ALIAS: reg_rdata <= read_word(bridge_alias, 1'b0);
        `RBR_OFS_TARGET_ADDR: reg_rdata <= read_word(target_addr, 1'b0);
        `RBR_OFS_TARGET_ALIAS: reg_rdata <= read_word(target_alias, 1'b0);
        `RBR_OFS_STATUS: reg_rdata <= {6'h00, learned_once, rx_lock};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  always_comb begin
    next_fwd_addr = 7'h00;
    next_ok = 1'b0;
    case (sel)
      RBR_SEL_BRIDGE: begin
        next_fwd_addr = bridge_addr;
        next_ok = (bridge_addr != 7'h00);
      end
      RBR_SEL_TARGET: begin
        next_fwd_addr = target_addr;
        next_ok = (target_addr != 7'h00);
      end
      default: begin
        next_fwd_addr = 7'h00;
        next_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fwd_valid <= 1'b0;
    end else begin
      fwd_valid <= req_valid && next_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_reject <= 1'b0;
    end else begin
      req_reject <= req_valid && (sel != RBR_SEL_NONE) && !next_ok;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fwd_addr <= `RBR_RST_ADDR;
      fwd_rnw <= 1'b0;
    end else if (req_valid && next_ok) begin
      fwd_addr <= next_fwd_addr;
      fwd_rnw <= req_rnw;
    end
  end

  zero_bridge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_BRIDGE && bridge_addr == 7'h00 |=> !fwd_valid && req_reject)
    else $error("forward with zero bridge address");
  bridge_learn_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rx_lock && learn_valid && !hold_learned_address && !reg_wr |=> bridge_addr == $past(learn_addr))
    else $error("learned address not loaded");
  hold_keeps_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    hold_learned_address && !reg_wr |=> $stable(bridge_addr))
    else $error("held address changed");
  bridge_remap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_BRIDGE && bridge_addr != 7'h00 |=> fwd_valid && fwd_addr == $past(bridge_addr))
    else $error("bridge remap wrong");
  target_remap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_TARGET && target_addr != 7'h00 |=> fwd_valid && fwd_addr == $past(target_addr))
    else $error("target remap wrong");
  zero_target_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_TARGET && target_addr == 7'h00 |=> !fwd_valid)
    else $error("forward with zero target");
  alias_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    target_alias == 7'h00 && bridge_alias == 7'h00 |-> sel == RBR_SEL_NONE)
    else $error("zero alias matched");
  no_match_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_NONE |=> !fwd_valid && !req_reject)
    else $error("unmatched forwarded");
  read_bridge_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `RBR_OFS_BRIDGE_ADDR |=> reg_rdata == {$past(bridge_addr), $past(hold_learned_address)})
    else $error("bridge readback wrong");

  write_field_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bridge_wr |=> bridge_addr == $past(reg_wdata[7:1]))
    else $error("written address not stored");
  hold_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bridge_wr |=> hold_learned_address == $past(reg_wdata[0]))
    else $error("hold bit not stored");
  write_wins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bridge_wr && rx_lock && learn_valid |=> bridge_addr == $past(reg_wdata[7:1]))
    else $error("learn beat a write");
  hold_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !bridge_wr |=> $stable(hold_learned_address))
    else $error("hold bit changed without write");
  no_lock_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !rx_lock && !bridge_wr |=> $stable(bridge_addr))
    else $error("address changed without lock");
  no_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !learn_valid && !bridge_wr |=> $stable(bridge_addr))
    else $error("address changed without learn pulse");
  learned_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    learn_take |=> learned_once)
    else $error("learn not recorded");
  status_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `RBR_OFS_STATUS |=>
      reg_rdata == {6'h00, $past(learned_once), $past(rx_lock)})
    else $error("status readback wrong");

  alias_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == `RBR_OFS_BRIDGE_ALIAS |=> bridge_alias == $past(reg_wdata[7:1]))
    else $error("bridge alias not stored");
  taddr_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == `RBR_OFS_TARGET_ADDR |=> target_addr == $past(reg_wdata[7:1]))
    else $error("target address not stored");
  talias_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr == `RBR_OFS_TARGET_ALIAS |=> target_alias == $past(reg_wdata[7:1]))
    else $error("target alias not stored");
  other_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_wr && reg_addr > `RBR_OFS_TARGET_ALIAS |=>
      $stable(bridge_alias) && $stable(target_addr) && $stable(target_alias))
    else $error("unmapped write changed a field");
  read_alias_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `RBR_OFS_BRIDGE_ALIAS |=> reg_rdata == {$past(bridge_alias), 1'b0})
    else $error("bridge alias readback wrong");
  read_taddr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `RBR_OFS_TARGET_ADDR |=> reg_rdata == {$past(target_addr), 1'b0})
    else $error("target address readback wrong");
  read_talias_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == `RBR_OFS_TARGET_ALIAS |=> reg_rdata == {$past(target_alias), 1'b0})
    else $error("target alias readback wrong");
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");

  bridge_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bridge_alias != 7'h00 && req_addr == bridge_alias |-> sel == RBR_SEL_BRIDGE)
    else $error("bridge alias not decoded");
  bridge_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    bridge_alias == 7'h00 |-> sel != RBR_SEL_BRIDGE)
    else $error("zero bridge alias decoded");
  target_hit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    target_alias != 7'h00 && req_addr == target_alias && req_addr != bridge_alias
      |-> sel == RBR_SEL_TARGET)
    else $error("target alias not decoded");
  target_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    target_alias == 7'h00 |-> sel != RBR_SEL_TARGET)
    else $error("zero target alias decoded");
  miss_none_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_addr != bridge_alias && req_addr != target_alias |-> sel == RBR_SEL_NONE)
    else $error("unmatched address decoded");

  rnw_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel != RBR_SEL_NONE && next_ok |=> fwd_rnw == $past(req_rnw))
    else $error("direction not forwarded");
  quiet_idle_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !req_valid |=> !fwd_valid && !req_reject)
    else $error("output without request");
  reject_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_reject |-> !fwd_valid)
    else $error("reject and forward together");
  zero_target_rej_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_TARGET && target_addr == 7'h00 |=> req_reject)
    else $error("zero target not rejected");
  bridge_ok_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    req_valid && sel == RBR_SEL_BRIDGE && bridge_addr != 7'h00 |=> !req_reject)
    else $error("valid bridge rejected");
  fwd_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !(req_valid && next_ok) |=> $stable(fwd_addr) && $stable(fwd_rnw))
    else $error("forward fields changed");

  bridge_fwd_c: cover property (@(posedge sys_clk) req_valid && sel == RBR_SEL_BRIDGE ##1 fwd_valid);
  target_fwd_c: cover property (@(posedge sys_clk) req_valid && sel == RBR_SEL_TARGET ##1 fwd_valid);
  learn_c: cover property (@(posedge sys_clk) rx_lock && learn_valid && !hold_learned_address);
  reject_c: cover property (@(posedge sys_clk) req_reject);
  hold_c: cover property (@(posedge sys_clk) hold_learned_address && rx_lock && learn_valid);
endmodule
`default_nettype wire

/* hdl/rbr_map.svh */
`ifndef RBR_MAP_SVH
`define RBR_MAP_SVH
`define RBR_OFS_BRIDGE_ADDR 8'h06
`define RBR_OFS_BRIDGE_ALIAS 8'h07
`define RBR_OFS_TARGET_ADDR 8'h08
`define RBR_OFS_TARGET_ALIAS 8'h09
`define RBR_OFS_STATUS 8'h0A
`define RBR_HOLD_BIT 0
`define RBR_RST_REG 8'h00
`define RBR_RST_ADDR 7'h00
`define RBR_ADDR_MSB 7
`define RBR_ADDR_LSB 1
`endif

/* hdl/rbr_pkg.sv */
package rbr_pkg;
  typedef logic [6:0] rbr_addr_t;
  typedef logic [7:0] rbr_byte_t;
  typedef enum logic [1:0] {
    RBR_SEL_NONE = 2'b00,
    RBR_SEL_BRIDGE = 2'b01,
    RBR_SEL_TARGET = 2'b10
  } rbr_sel_t;
endpackage

/* hdl/rbr_decode.sv */
`timescale 1ns/10ps
`default_nettype none
module rbr_decode (
  input wire rbr_pkg::rbr_addr_t req_addr,
  input wire rbr_pkg::rbr_addr_t bridge_alias,
  input wire rbr_pkg::rbr_addr_t target_alias,
  output rbr_pkg::rbr_sel_t sel
);
  import rbr_pkg::*;
  function automatic logic alias_hit(input rbr_addr_t a, input rbr_addr_t al);
    alias_hit = (al != 7'h00) && (a == al);
  endfunction
  always_comb begin
    sel = RBR_SEL_NONE;
    if (alias_hit(req_addr, bridge_alias)) begin
      sel = RBR_SEL_BRIDGE;
    end else if (alias_hit(req_addr, target_alias)) begin
      sel = RBR_SEL_TARGET;
    end
  end
endmodule
`default_nettype wire

/* testbench/rbr_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rbr_far_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic lock_en,
  input wire rbr_pkg::rbr_addr_t next_addr,
  output logic rx_lock,
  output logic learn_valid,
  output rbr_pkg::rbr_addr_t learn_addr
);
  assign rx_lock = lock_en;
  always_ff @(posedge sys_clk) begin
    learn_valid <= go;
    learn_addr <= go ? next_addr : ~learn_addr;
  end
endmodule
`default_nettype wire

/* testbench/rbr_remap_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module rbr_remap_bench;
  import rbr_pkg::*;
  logic sys_clk, sys_rst, reg_wr, reg_rd, req_valid, req_rnw, rd_q, go, lock_en;
  logic fwd_valid, fwd_rnw, req_reject, rx_lock, learn_valid;
  rbr_byte_t reg_addr, reg_wdata, reg_rdata;
  rbr_addr_t req_addr, learn_addr, fwd_addr, pa, a1, a2, a3, pb;
  logic [9:0] exp_q[$];
  int n_fail, total_checks, seed, i;
  rbr_remap dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_lock(rx_lock), .learn_valid(learn_valid), .learn_addr(learn_addr),
    .req_valid(req_valid), .req_addr(req_addr), .req_rnw(req_rnw), .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr), .fwd_rnw(fwd_rnw), .req_reject(req_reject));
  rbr_far_model far (.sys_clk(sys_clk), .go(go), .lock_en(lock_en), .next_addr(pa),
    .rx_lock(rx_lock), .learn_valid(learn_valid), .learn_addr(learn_addr));
  initial begin
    sys_clk = 0;
    forever #2 sys_clk = ~sys_clk;
  end
  task chk(input logic [9:0] s, input logic [9:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  function automatic logic [9:0] oldest();
    oldest = exp_q.size() ? exp_q.pop_front() : 10'h3FF;
  endfunction
  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q) chk({2'b00, reg_rdata}, oldest());
    if (fwd_valid) chk({2'b01, fwd_rnw, fwd_addr}, oldest());
    if (req_reject) chk(10'h200, oldest());
  end
  task wr(input rbr_byte_t a, input rbr_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task rd(input rbr_byte_t a, input rbr_byte_t e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    exp_q.push_back({2'b00, e});
    @(posedge sys_clk);
    reg_rd <= 0;
  endtask
  task req(input rbr_addr_t a, input logic [9:0] e);
    @(posedge sys_clk);
    req_addr <= a;
    req_rnw <= a[0];
    req_valid <= 1;
    if (e != 0) exp_q.push_back(e);
    @(posedge sys_clk);
    req_valid <= 0;
  endtask
  task learn(input logic lk);
    @(posedge sys_clk);
    lock_en <= lk;
    go <= 1;
    @(posedge sys_clk);
    go <= 0;
    repeat (3) @(posedge sys_clk);
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    seed = 32'hdea673b8;
    {sys_rst, reg_wr, reg_rd, req_valid, req_rnw, go, lock_en} = 7'h40;
    {reg_addr, reg_wdata, req_addr} = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 0;
    for (i = 6; i < 12; i++) rd(i[7:0], 8'h00);
    req(7'h00, 0);
    $display("test reset done");
    pa = 7'($random(seed)) | 7'h01;
    a1 = 7'($random(seed)) | 7'h01;
    a2 = a1 ^ 7'h40;
    a3 = pa ^ 7'h10;
    pb = 7'($random(seed)) | 7'h02;
    learn(0);
    rd(8'h06, 8'h00);
    learn(1);
    rd(8'h06, {pa, 1'b0});
    rd(8'h0A, 8'h03);
    wr(8'h06, {a3, 1'b1});
    pa = pa ^ 7'h08;
    learn(1);
    rd(8'h06, {a3, 1'b1});
    $display("test learn done");
    wr(8'h07, {a1, 1'b1});
    wr(8'h09, {a2, 1'b0});
    wr(8'h08, {pb, 1'b0});
    wr(8'h0B, 8'hFF);
    rd(8'h07, {a1, 1'b0});
    rd(8'h0B, 8'h00);
    req(a1, {2'b01, a1[0], a3});
    req(a2, {2'b01, a2[0], pb});
    req(a1 ^ 7'h20, 0);
    wr(8'h08, 8'h00);
    req(a2, 10'h200);
    wr(8'h06, 8'h01);
    req(a1, 10'h200);
    wr(8'h09, 8'h00);
    req(a2, 0);
    wr(8'h07, 8'h00);
    req(a1, 0);
    $display("test remap done");
    sys_rst <= 1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 0;
    rd(8'h06, 8'h00);
    rd(8'h08, 8'h00);
    $display("test second reset done");
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge sys_clk);
    if (exp_q.size() > 0) n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
